// ===== rtl/pttx_pkg.sv
// Shared constants, types and carriers for the trellis transmit datapath
package pttx_pkg;

  // ---------------------------------------------------------------------
  // Coding and datapath widths
  // ---------------------------------------------------------------------
  localparam int unsigned PTTX_K_BITS = 3;
  localparam int unsigned PTTX_CODE_W = PTTX_K_BITS + 1;
  localparam int unsigned PTTX_COEF_TAPS = 21;
  localparam int unsigned PTTX_CONV_MEM = PTTX_COEF_TAPS - 1;
  localparam int unsigned PTTX_SCR_LEN = 23;
  localparam int unsigned PTTX_PREC_TAPS = 8;
  localparam int unsigned PTTX_PREC_IDX_W = $clog2(PTTX_PREC_TAPS);
  localparam int unsigned PTTX_LVL_W = 16;
  localparam int unsigned PTTX_FRAC = 12;
  localparam int unsigned PTTX_MOD_W = PTTX_FRAC + 1;
  localparam int unsigned PTTX_SIXT_SHIFT = PTTX_FRAC - 4;
  localparam logic signed [7:0] PTTX_PAM2_SIXT = 8'sh08;
  localparam logic signed [15:0] PTTX_LVL_MIN = 16'shf000;
  localparam logic signed [15:0] PTTX_LVL_MAX = 16'sh0fff;

  // ---------------------------------------------------------------------
  // Line rate and capability table
  // ---------------------------------------------------------------------
  localparam logic [5:0] PTTX_RATE_N_MIN = 6'h03;
  localparam logic [5:0] PTTX_RATE_N_MAX = 6'h24;
  localparam logic [15:0] PTTX_RATE_N_STEP = 16'h0040;
  localparam logic [15:0] PTTX_RATE_I_STEP = 16'h0008;
  localparam logic [15:0] PTTX_RATE_OVERHEAD = 16'h0008;
  localparam int unsigned PTTX_RATE_SLOTS = 34;

  // ---------------------------------------------------------------------
  // Power back-off
  // ---------------------------------------------------------------------
  localparam logic signed [8:0] PTTX_LOSS_FULL = 9'sh006;
  localparam logic [4:0] PTTX_BACKOFF_DFLT_MAX = 5'h06;
  localparam logic [7:0] PTTX_BACKOFF_MAX = 8'h1f;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [PTTX_COEF_TAPS-1:0] PTTX_COEF_RESET = 21'h000000;
  localparam logic [4:0] PTTX_BACKOFF_RESET = 5'h06;

  typedef enum logic [1:0] {
    PTTX_MODE_PREACT,
    PTTX_MODE_ACTIVATION,
    PTTX_MODE_DATA
  } pttx_mode_t;

  typedef struct packed {
    logic [PTTX_CODE_W-1:0] code;
    logic signed [PTTX_LVL_W-1:0] level;
  } pttx_sym_t;

  typedef struct packed {
    logic signed [7:0] snr_est;
    logic signed [7:0] margin;
    logic enable;
  } pttx_margin_t;

endpackage : pttx_pkg

// ===== rtl/pttx_buf.sv
// Two-entry symbol buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pttx_buf #(
  parameter int unsigned WIDTH = 20
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  typedef struct packed {
    logic [1:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
  } pttx_buf_state_t;

  pttx_buf_state_t st;
  pttx_buf_state_t next_st;
  logic push;
  logic pop;

  assign push = i_in_valid && st.in_ready;
  assign pop = st.out_valid && i_out_ready;

  always_comb begin
    next_st = st;
    case ({push, pop})
      2'b10: begin
        if (st.count == 2'h0) begin
          next_st.head = i_in_data;
        end else begin
          next_st.tail = i_in_data;
        end
        next_st.count = st.count + 2'h1;
      end
      2'b01: begin
        next_st.head = st.tail;
        next_st.count = st.count - 2'h1;
      end
      2'b11: begin
        if (st.count == 2'h1) begin
          next_st.head = i_in_data;
        end else begin
          next_st.head = st.tail;
          next_st.tail = i_in_data;
        end
      end
      default: begin
        next_st.count = st.count;
      end
    endcase
    // Ready as a flop keeps the source free of a combinational path
    next_st.in_ready = (next_st.count != 2'h2);
    next_st.out_valid = (next_st.count != 2'h0);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_in_ready = st.in_ready;
  assign o_out_valid = st.out_valid;
  assign o_out_data = st.head;

endmodule : pttx_buf
`default_nettype wire

// ===== rtl/pttx_datapath.sv
// Transmit datapath: scrambler, packer, trellis coder, mapper, precoder, back-off and margin check
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Line rate n*64+i*8+8 kbit/s supported
// - Data symbol: three info bits, one redundant
// - Sync/stuff bits bypass, scrambler holds state
// - Pack K bits, earliest bit into X1
// - K bits become K+1 bits, select level
// - Encoder outputs computed before X1 shifts
// - Tap sets A, B loaded from far end
// - Four-bit code maps to odd sixteenths
// - Filter sums coefficient times delayed output
// - Modulo wraps output into [-1, +1)
// - Data mode precoder, else mapper output
// - Probe bits mapped uncoded, no precoding
// - Probe: two-level, scrambler input constant one
// - Probe scrambler cleared before probe starts
// - Back-off conveyed to peer via handshake
// - Loss is transmit minus receive power
// - Default back-off from loss band table
// - Back-off clamped between default and 31
// - Rate listed only if margin is met
// - Both margins given: intersect rate sets
// - Line probe selected: apply negotiated margin
module pttx_datapath
  import pttx_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire pttx_pkg::pttx_mode_t i_mode,
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_bit_bypass,
  output logic o_bit_ready,
  input wire logic [pttx_pkg::PTTX_SCR_LEN-1:0] i_scr_taps,
  input wire logic i_scr_invert,
  input wire logic i_probe_start,
  input wire logic i_probe_active,
  input wire logic i_coef_load,
  input wire logic [pttx_pkg::PTTX_COEF_TAPS-1:0] i_coef_a,
  input wire logic [pttx_pkg::PTTX_COEF_TAPS-1:0] i_coef_b,
  input wire logic i_prec_load,
  input wire logic [pttx_pkg::PTTX_PREC_IDX_W-1:0] i_prec_index,
  input wire logic [pttx_pkg::PTTX_LVL_W-1:0] i_prec_value,
  output logic o_sym_valid,
  output pttx_pkg::pttx_sym_t o_sym,
  input wire logic i_sym_ready,
  input wire logic [5:0] i_rate_n,
  input wire logic [2:0] i_rate_i,
  output logic [15:0] o_line_rate_kbps,
  output logic o_rate_ok,
  input wire logic signed [7:0] i_tx_power_db,
  input wire logic signed [7:0] i_est_rx_power_db,
  input wire logic [7:0] i_backoff_request_db,
  output logic signed [8:0] o_estimated_power_loss,
  output logic [4:0] o_power_backoff_db,
  input wire logic i_line_probe_selected,
  input wire logic i_rate_eval,
  input wire logic [5:0] i_rate_slot,
  input wire logic signed [7:0] i_snr_required,
  input wire pttx_pkg::pttx_margin_t i_margin_worst,
  input wire pttx_pkg::pttx_margin_t i_margin_current,
  input wire logic i_cap_clear,
  output logic [pttx_pkg::PTTX_RATE_SLOTS-1:0] o_capability
);
  import pttx_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic bit_ready;
    logic [PTTX_K_BITS-1:0] word;
    logic [1:0] bit_cnt;
    logic [PTTX_SCR_LEN-1:0] scr_hist;
    logic [PTTX_CONV_MEM-1:0] conv_hist;
    logic [PTTX_COEF_TAPS-1:0] coef_a;
    logic [PTTX_COEF_TAPS-1:0] coef_b;
    logic [PTTX_PREC_TAPS-1:0][PTTX_LVL_W-1:0] prec_coef;
    logic [PTTX_PREC_TAPS-1:0][PTTX_LVL_W-1:0] prec_hist;
    logic pend;
    pttx_sym_t pend_sym;
    logic signed [8:0] loss;
    logic [4:0] backoff;
    logic [15:0] line_rate;
    logic rate_ok;
    logic [PTTX_RATE_SLOTS-1:0] cap;
  } pttx_state_t;

  pttx_state_t st;
  pttx_state_t next_st;
  logic buf_ready;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic signed [7:0] pttx_sixteenths(input logic [PTTX_CODE_W-1:0] code);
    logic signed [7:0] lvl;
    lvl = 8'sh00;
    if (!code[3]) begin
      lvl = 8'(-15 + 2 * int'(code[2:0]));
    end else if (code[2]) begin
      lvl = 8'(1 + 2 * int'(code[1:0]));
    end else begin
      lvl = 8'(9 + 2 * int'(code[1:0]));
    end
    return lvl;
  endfunction : pttx_sixteenths

  function automatic logic signed [PTTX_LVL_W-1:0] pttx_level(input logic signed [7:0] sixt);
    // Widen before shifting so no level bits fall off the top
    return PTTX_LVL_W'(sixt) <<< PTTX_SIXT_SHIFT;
  endfunction : pttx_level

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  logic take;
  logic d_in;
  logic s_out;
  logic scr_fb;
  logic x1;
  logic y1;
  logic y0;
  logic [PTTX_K_BITS-1:0] word_full;
  logic [PTTX_COEF_TAPS-1:0] conv_taps;
  logic [PTTX_CODE_W-1:0] code;
  logic signed [PTTX_LVL_W-1:0] x_lvl;
  logic signed [31:0] acc;
  logic signed [PTTX_LVL_W-1:0] v_lvl;
  logic signed [PTTX_LVL_W:0] u_lvl;
  logic signed [PTTX_LVL_W-1:0] y_lvl;
  logic signed [8:0] loss;
  logic [4:0] backoff_dflt;
  logic [4:0] backoff_req;
  logic signed [8:0] diff_wc;
  logic signed [8:0] diff_cur;
  logic qual;

  always_comb begin
    next_st = st;
    take = 1'b0;
    d_in = i_bit;
    s_out = 1'b0;
    scr_fb = 1'b0;
    x1 = 1'b0;
    y1 = 1'b0;
    y0 = 1'b0;
    word_full = st.word;
    conv_taps = '0;
    code = '0;
    x_lvl = '0;
    acc = '0;
    v_lvl = '0;
    u_lvl = '0;
    y_lvl = '0;
    loss = '0;
    backoff_dflt = '0;
    backoff_req = '0;
    diff_wc = '0;
    diff_cur = '0;
    qual = 1'b0;

    // A symbol held for the buffer leaves before the next one forms
    if (st.pend && buf_ready) begin
      next_st.pend = 1'b0;
    end

    if (i_coef_load) begin
      next_st.coef_a = i_coef_a;
      next_st.coef_b = i_coef_b;
    end
    if (i_prec_load) begin
      next_st.prec_coef[i_prec_index] = i_prec_value;
    end

    // Scrambler: data mode uses the bit stream, probe feeds constant ones
    if (i_mode == PTTX_MODE_PREACT) begin
      take = i_probe_active && !st.pend && !i_probe_start;
      d_in = 1'b1;
    end else begin
      take = i_bit_valid && st.bit_ready;
    end
    scr_fb = ^(st.scr_hist & i_scr_taps);
    s_out = d_in ^ scr_fb ^ i_scr_invert;

    if (take) begin
      if (i_mode == PTTX_MODE_DATA && i_bit_bypass) begin
        s_out = i_bit;
      end else begin
        next_st.scr_hist = {st.scr_hist[PTTX_SCR_LEN-2:0], s_out};
      end
    end
    if (i_probe_start) begin
      next_st.scr_hist = '0;
    end

    if (take && i_mode == PTTX_MODE_DATA) begin
      word_full[st.bit_cnt] = s_out;
      next_st.word = word_full;
      next_st.bit_cnt = st.bit_cnt + 2'h1;
      if (st.bit_cnt == 2'(PTTX_K_BITS - 1)) begin
        next_st.bit_cnt = 2'h0;
        // Outputs use the register as it stands, then X1 enters it
        x1 = word_full[0];
        conv_taps = {st.conv_hist, x1};
        y1 = ^(st.coef_a & conv_taps);
        y0 = ^(st.coef_b & conv_taps);
        next_st.conv_hist = {st.conv_hist[PTTX_CONV_MEM-2:0], x1};
        code = {word_full[2], word_full[1], y1, y0};
        x_lvl = pttx_level(pttx_sixteenths(code));
        for (int k = 0; k < PTTX_PREC_TAPS; k++) begin
          acc = acc + $signed(st.prec_coef[k]) * $signed(st.prec_hist[k]);
        end
        v_lvl = PTTX_LVL_W'(acc >>> PTTX_FRAC);
        u_lvl = (PTTX_LVL_W + 1)'(x_lvl) - (PTTX_LVL_W + 1)'(v_lvl);
        // Keeping the low bits adds the multiple of two that wraps u
        y_lvl = PTTX_LVL_W'($signed(u_lvl[PTTX_MOD_W-1:0]));
        next_st.prec_hist = {st.prec_hist[PTTX_PREC_TAPS-2:0], y_lvl};
        next_st.pend = 1'b1;
        next_st.pend_sym.code = code;
        next_st.pend_sym.level = y_lvl;
      end
    end else if (take) begin
      // Uncoded two-level symbol straight from the mapper
      next_st.bit_cnt = 2'h0;
      next_st.pend = 1'b1;
      next_st.pend_sym.code = {3'h0, s_out};
      next_st.pend_sym.level = s_out ? pttx_level(PTTX_PAM2_SIXT) : pttx_level(-PTTX_PAM2_SIXT);
    end
    if (i_mode != PTTX_MODE_DATA) begin
      next_st.bit_cnt = 2'h0;
    end
    next_st.bit_ready = !next_st.pend && (i_mode != PTTX_MODE_PREACT);

    // Line rate figure for the configured n and i
    next_st.line_rate = PTTX_RATE_N_STEP * 16'(i_rate_n) + PTTX_RATE_I_STEP * 16'(i_rate_i)
                        + PTTX_RATE_OVERHEAD;
    next_st.rate_ok = (i_rate_n >= PTTX_RATE_N_MIN) && (i_rate_n <= PTTX_RATE_N_MAX);

    // Back-off: default from the loss band, request clamped to [default, 31]
    loss = 9'(i_tx_power_db) - 9'(i_est_rx_power_db);
    if (loss >= PTTX_LOSS_FULL) begin
      backoff_dflt = 5'h00;
    end else if (loss < 9'sh000) begin
      // Negative loss treated as the shortest band
      backoff_dflt = PTTX_BACKOFF_DFLT_MAX;
    end else begin
      backoff_dflt = PTTX_BACKOFF_DFLT_MAX - 5'(loss[2:0]);
    end
    backoff_req = (i_backoff_request_db > PTTX_BACKOFF_MAX) ? 5'(PTTX_BACKOFF_MAX) : i_backoff_request_db[4:0];
    next_st.backoff = (backoff_req < backoff_dflt) ? backoff_dflt : backoff_req;
    next_st.loss = loss;

    // Capability list from the probe, each margin mode a separate filter
    diff_wc = 9'(i_margin_worst.snr_est) - 9'(i_snr_required);
    diff_cur = 9'(i_margin_current.snr_est) - 9'(i_snr_required);
    qual = (!i_margin_worst.enable || diff_wc >= 9'(i_margin_worst.margin))
           && (!i_margin_current.enable || diff_cur >= 9'(i_margin_current.margin));
    if (i_cap_clear) begin
      next_st.cap = '0;
    end
    // A write in the clearing cycle still lands
    if (i_rate_eval && i_line_probe_selected && i_rate_slot < 6'(PTTX_RATE_SLOTS)) begin
      next_st.cap[i_rate_slot] = qual;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st <= '0;
      st.coef_a <= PTTX_COEF_RESET;
      st.coef_b <= PTTX_COEF_RESET;
      st.backoff <= PTTX_BACKOFF_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // Output buffer
  // ---------------------------------------------------------------------
  pttx_buf #(
    .WIDTH($bits(pttx_sym_t))
  ) u_buf (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_in_valid(st.pend),
    .i_in_data(st.pend_sym),
    .o_in_ready(buf_ready),
    .o_out_valid(o_sym_valid),
    .o_out_data(o_sym),
    .i_out_ready(i_sym_ready)
  );

  assign o_bit_ready = st.bit_ready;
  assign o_line_rate_kbps = st.line_rate;
  assign o_rate_ok = st.rate_ok;
  assign o_estimated_power_loss = st.loss;
  assign o_power_backoff_db = st.backoff;
  assign o_capability = st.cap;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  chk_bypass_hold: assert property (
    (i_mode == PTTX_MODE_DATA && take && i_bit_bypass && !i_probe_start) |=> $stable(st.scr_hist))
    else $error("scrambler advanced on bypass bit");
  chk_probe_clear: assert property (
    i_probe_start |=> (st.scr_hist == '0))
    else $error("probe scrambler not cleared");
  chk_coef_load: assert property (
    i_coef_load |=> (st.coef_a == $past(i_coef_a) && st.coef_b == $past(i_coef_b)))
    else $error("tap sets not loaded");
  chk_modulo_range: assert property (
    (st.pend && i_mode == PTTX_MODE_DATA && $past(i_mode) == PTTX_MODE_DATA)
    |-> ($signed(st.pend_sym.level) >= PTTX_LVL_MIN && $signed(st.pend_sym.level) <= PTTX_LVL_MAX))
    else $error("precoder output out of range");
  chk_probe_uncoded: assert property (
    (i_mode == PTTX_MODE_PREACT && take) |=> (st.pend && st.pend_sym.code[3:1] == 3'h0
    && (st.pend_sym.code[0] ? $signed(st.pend_sym.level) == pttx_level(PTTX_PAM2_SIXT)
        : $signed(st.pend_sym.level) == pttx_level(-PTTX_PAM2_SIXT))))
    else $error("probe symbol not two-level");
  chk_pack_count: assert property (
    st.bit_cnt < 2'(PTTX_K_BITS))
    else $error("bit counter beyond word");
  chk_backoff_default: assert property (
    ($signed(loss) >= PTTX_LOSS_FULL && i_backoff_request_db == 8'h00) |=> (st.backoff == 5'h00))
    else $error("default back-off wrong at full loss");
  chk_backoff_clamp: assert property (
    ##1 (st.backoff >= $past(backoff_dflt) && st.backoff <= 5'(PTTX_BACKOFF_MAX)))
    else $error("back-off outside clamp");
  chk_rate_formula: assert property (
    (i_rate_n == 6'h03 && i_rate_i == 3'h0) |=> (st.line_rate == 16'h00c8 && st.rate_ok))
    else $error("line rate formula wrong");
  chk_cap_intersect: assert property (
    (i_rate_eval && i_line_probe_selected && i_rate_slot < 6'(PTTX_RATE_SLOTS) && i_margin_worst.enable
     && i_margin_current.enable && diff_cur < 9'(i_margin_current.margin)) |=> !st.cap[$past(i_rate_slot)])
    else $error("rate listed despite failed margin");
  chk_no_probe_sel: assert property (
    (!i_line_probe_selected && !i_cap_clear) |=> $stable(st.cap))
    else $error("capability written without line probe");

  cov_data_symbol: cover property (i_mode == PTTX_MODE_DATA && st.pend && buf_ready);
  cov_probe_symbol: cover property (i_mode == PTTX_MODE_PREACT && st.pend ##1 o_sym_valid);
  cov_bypass_bit: cover property (i_mode == PTTX_MODE_DATA && take && i_bit_bypass);
  cov_stall: cover property (st.pend && !buf_ready);

endmodule : pttx_datapath
`default_nettype wire

// ===== verif/pttx_sink.sv
// Symbol sink standing in for the shaper and line side
`timescale 1ns/100ps
`default_nettype none
module pttx_sink
  import pttx_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_valid,
  input wire pttx_pkg::pttx_sym_t i_sym,
  input wire logic i_hold,
  input wire logic i_slow,
  output logic o_ready
);
  pttx_sym_t rx_q[$];
  logic phase = 1'b0;
  // Ready moves on the falling edge, away from the sampling edge
  always @(negedge i_clock) begin
    phase <= ~phase;
    o_ready <= !i_reset && !i_hold && (!i_slow || phase);
  end
  // Shaper input arrives in stream order
  always @(posedge i_clock) begin
    if (!i_reset && i_valid && o_ready) begin
      rx_q.push_back(i_sym);
    end
  end
endmodule : pttx_sink
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the trellis transmit datapath
`timescale 1ns/100ps
`default_nettype none
module testbench
  import pttx_pkg::*;
();
  logic i_clock, i_reset, i_bit_valid, i_bit, i_bit_bypass, i_scr_invert, i_probe_start, i_probe_active;
  logic i_coef_load, i_prec_load, i_line_probe_selected, i_rate_eval, i_cap_clear, hold, slow;
  pttx_mode_t i_mode;
  logic [PTTX_SCR_LEN-1:0] i_scr_taps;
  logic [PTTX_COEF_TAPS-1:0] i_coef_a, i_coef_b;
  logic [PTTX_PREC_IDX_W-1:0] i_prec_index;
  logic [PTTX_LVL_W-1:0] i_prec_value;
  logic [5:0] i_rate_n, i_rate_slot;
  logic [2:0] i_rate_i;
  logic signed [7:0] i_tx_power_db, i_est_rx_power_db, i_snr_required;
  logic [7:0] i_backoff_request_db;
  pttx_margin_t i_margin_worst, i_margin_current;
  logic o_bit_ready, o_sym_valid, o_rate_ok, sym_ready;
  pttx_sym_t o_sym;
  logic [15:0] o_line_rate_kbps;
  logic signed [8:0] o_estimated_power_loss;
  logic [4:0] o_power_backoff_db;
  logic [PTTX_RATE_SLOTS-1:0] o_capability;
  int errors;
  int samples_checked;

  pttx_datapath u_pttx_datapath (.i_clock(i_clock), .i_reset(i_reset), .i_mode(i_mode),
    .i_bit_valid(i_bit_valid), .i_bit(i_bit), .i_bit_bypass(i_bit_bypass), .o_bit_ready(o_bit_ready),
    .i_scr_taps(i_scr_taps), .i_scr_invert(i_scr_invert), .i_probe_start(i_probe_start),
    .i_probe_active(i_probe_active), .i_coef_load(i_coef_load), .i_coef_a(i_coef_a), .i_coef_b(i_coef_b),
    .i_prec_load(i_prec_load), .i_prec_index(i_prec_index), .i_prec_value(i_prec_value),
    .o_sym_valid(o_sym_valid), .o_sym(o_sym), .i_sym_ready(sym_ready), .i_rate_n(i_rate_n),
    .i_rate_i(i_rate_i), .o_line_rate_kbps(o_line_rate_kbps), .o_rate_ok(o_rate_ok),
    .i_tx_power_db(i_tx_power_db), .i_est_rx_power_db(i_est_rx_power_db),
    .i_backoff_request_db(i_backoff_request_db), .o_estimated_power_loss(o_estimated_power_loss),
    .o_power_backoff_db(o_power_backoff_db), .i_line_probe_selected(i_line_probe_selected),
    .i_rate_eval(i_rate_eval), .i_rate_slot(i_rate_slot), .i_snr_required(i_snr_required),
    .i_margin_worst(i_margin_worst), .i_margin_current(i_margin_current), .i_cap_clear(i_cap_clear),
    .o_capability(o_capability));

  pttx_sink u_pttx_sink (.i_clock(i_clock), .i_reset(i_reset), .i_valid(o_sym_valid), .i_sym(o_sym),
    .i_hold(hold), .i_slow(slow), .o_ready(sym_ready));

  // ---------------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------------
  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic send_bit(input logic b, input logic byp);
    int n;
    n = 0;
    i_bit = b;
    i_bit_bypass = byp;
    i_bit_valid = 1'b1;
    // Ready is a flop, so its falling-edge value is what the next edge sees
    while (o_bit_ready !== 1'b1 && n < 100) begin
      @(negedge i_clock);
      n++;
    end
    check(64'(n < 100), 64'h1, "bit accepted");
    @(negedge i_clock);
  endtask : send_bit

  task automatic send_word(input logic [2:0] d, input logic [2:0] byp);
    for (int j = 0; j < 3; j++) begin
      send_bit(d[j], byp[j]);
    end
  endtask : send_word

  task automatic wait_syms(input int n);
    int k;
    k = 0;
    while (u_pttx_sink.rx_q.size() < n && k < 500) begin
      @(negedge i_clock);
      k++;
    end
    check(64'(k < 500), 64'h1, "symbols arrived");
  endtask : wait_syms

  task automatic chk_sym(input int idx, input logic [19:0] exp, input logic [19:0] mask);
    check(64'(u_pttx_sink.rx_q[idx] & mask), 64'(exp), "symbol");
  endtask : chk_sym

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic rate_case(input int n, input int i, input logic ok);
    i_rate_n = 6'(n);
    i_rate_i = 3'(i);
    repeat (2) @(negedge i_clock);
    check(64'(o_line_rate_kbps), 64'(n * 64 + i * 8 + 8), "line rate");
    check(64'(o_rate_ok), 64'(ok), "rate ok");
  endtask : rate_case

  task automatic backoff_case(input int l, input int req, input int exp);
    i_tx_power_db = 8'(20);
    i_est_rx_power_db = 8'(20 - l);
    i_backoff_request_db = 8'(req);
    repeat (2) @(negedge i_clock);
    check(64'(o_estimated_power_loss), 64'(l), "loss");
    check(64'(o_power_backoff_db), 64'(exp), "backoff");
  endtask : backoff_case

  task automatic cap_eval(input logic sel, input int slot, input int ws, input int wm, input logic we,
                          input int cs, input int cm, input logic ce);
    i_line_probe_selected = sel;
    i_rate_slot = 6'(slot);
    i_snr_required = 8'(20);
    i_margin_worst = '{8'(ws), 8'(wm), we};
    i_margin_current = '{8'(cs), 8'(cm), ce};
    i_rate_eval = 1'b1;
    @(negedge i_clock);
    i_rate_eval = 1'b0;
    @(negedge i_clock);
  endtask : cap_eval

  task automatic capability_test();
    check(64'(o_capability), 64'h0, "capability after reset");
    cap_eval(1'b0, 5, 30, 10, 1'b1, 0, 0, 1'b0);
    check(64'(o_capability), 64'h0, "eval without probe");
    cap_eval(1'b1, 5, 30, 10, 1'b1, 0, 0, 1'b0);
    cap_eval(1'b1, 6, 30, 10, 1'b1, 25, 6, 1'b1);
    cap_eval(1'b1, 7, 18, -3, 1'b1, 0, 0, 1'b0);
    cap_eval(1'b1, 33, 21, 1, 1'b1, 21, 1, 1'b1);
    cap_eval(1'b1, 34, 30, 0, 1'b1, 30, 0, 1'b1);
    check(64'(o_capability), 64'h2_0000_00a0, "capability set");
    i_cap_clear = 1'b1;
    @(negedge i_clock);
    i_cap_clear = 1'b0;
    @(negedge i_clock);
    check(64'(o_capability), 64'h0, "capability cleared");
  endtask : capability_test

  task automatic data_test();
    logic [2:0] words [5] = '{3'b010, 3'b111, 3'b010, 3'b111, 3'b010};
    logic [19:0] exp [5] = '{20'hf0700, 20'h0f100, 20'hb0f00, 20'h00200, 20'hb0d00};
    i_mode = PTTX_MODE_DATA;
    i_scr_invert = 1'b1;
    i_coef_a = 21'h000001;
    i_coef_b = 21'h000001;
    i_coef_load = 1'b1;
    @(negedge i_clock);
    i_coef_load = 1'b0;
    hold = 1'b1;
    send_word(words[0], 3'b010);
    send_word(words[1], 3'b000);
    send_word(words[2], 3'b000);
    i_bit_valid = 1'b0;
    repeat (4) @(negedge i_clock);
    check(64'(o_bit_ready), 64'h0, "ready while stalled");
    hold = 1'b0;
    slow = 1'b1;
    wait_syms(3);
    for (int k = 0; k < 3; k++) begin
      chk_sym(k, exp[k], 20'hfffff);
    end
    i_prec_index = '0;
    i_prec_value = 16'h1000;
    i_prec_load = 1'b1;
    @(negedge i_clock);
    i_prec_load = 1'b0;
    send_word(words[3], 3'b000);
    send_word(words[4], 3'b000);
    i_bit_valid = 1'b0;
    wait_syms(5);
    for (int k = 3; k < 5; k++) begin
      chk_sym(k, exp[k], 20'hfffff);
    end
    slow = 1'b0;
    u_pttx_sink.rx_q.delete();
  endtask : data_test

  task automatic probe_test();
    i_mode = PTTX_MODE_PREACT;
    i_scr_invert = 1'b0;
    i_scr_taps = 23'h000001;
    i_probe_start = 1'b1;
    @(negedge i_clock);
    i_probe_start = 1'b0;
    i_probe_active = 1'b1;
    wait_syms(4);
    i_probe_active = 1'b0;
    for (int k = 0; k < 4; k++) begin
      chk_sym(k, (k % 2 == 1) ? 20'h0f800 : 20'h10800, 20'hfffff);
    end
    repeat (6) @(negedge i_clock);
    u_pttx_sink.rx_q.delete();
    // Activation maps bits uncoded; bypass has no effect here
    i_mode = PTTX_MODE_ACTIVATION;
    i_scr_taps = '0;
    i_scr_invert = 1'b1;
    send_bit(1'b1, 1'b1);
    send_bit(1'b0, 1'b0);
    i_bit_valid = 1'b0;
    wait_syms(2);
    chk_sym(0, 20'h0f800, 20'hfffff);
    chk_sym(1, 20'h10800, 20'hfffff);
  endtask : probe_test

  // ---------------------------------------------------------------------
  // Clock, main sequence and watchdog
  // ---------------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    i_reset = 1'b1;
    i_mode = PTTX_MODE_DATA;
    {i_bit_valid, i_bit, i_bit_bypass, i_scr_invert, i_probe_start, i_probe_active, i_coef_load} = '0;
    {i_prec_load, i_line_probe_selected, i_rate_eval, i_cap_clear, hold, slow} = '0;
    i_scr_taps = '0;
    i_coef_a = '0;
    i_coef_b = '0;
    i_prec_index = '0;
    i_prec_value = '0;
    {i_rate_n, i_rate_slot, i_rate_i} = '0;
    {i_tx_power_db, i_est_rx_power_db, i_snr_required, i_backoff_request_db} = '0;
    i_margin_worst = '0;
    i_margin_current = '0;
    repeat (8) @(negedge i_clock);
    i_reset = 1'b0;
    repeat (2) @(negedge i_clock);
    check(64'(o_power_backoff_db), 64'h6, "backoff after reset");
    check(64'(o_sym_valid), 64'h0, "valid after reset");
    rate_case(3, 0, 1'b1);
    rate_case(36, 7, 1'b1);
    rate_case(2, 7, 1'b0);
    rate_case(37, 0, 1'b0);
    for (int l = -1; l <= 7; l++) begin
      backoff_case(l, 0, (l >= 6) ? 0 : (l < 0) ? 6 : 6 - l);
    end
    backoff_case(10, 40, 31);
    backoff_case(2, 3, 4);
    backoff_case(2, 9, 9);
    capability_test();
    data_test();
    probe_test();
    results();
  end

  initial begin
    #200000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end
endmodule : testbench
`default_nettype wire
